// ===== rtl/bst_defs.svh
// Constants of the boundary-scan test access port.
// Assumes inclusion by bare name from the rtl folder.
`ifndef BST_DEFS_SVH
`define BST_DEFS_SVH

`define BST_IR_W        4
`define BST_IR_BYPASS   4'h0
`define BST_IR_SAMPLE   4'h1
`define BST_IR_IDCODE   4'h2
`define BST_IR_USERCODE 4'h3
`define BST_IR_CLAMP    4'h4
`define BST_IR_HIGHZ    4'h5
`define BST_IR_EXTEST   4'h7
`define BST_IR_IFSWITCH 4'h8
`define BST_IR_REGRD    4'h9
`define BST_IR_REGWR    4'ha
`define BST_IR_CAPTURE  4'h1

`define BST_DR_W        32
`define BST_BSR_LEN     24
`define BST_PADS        12
`define BST_OD_PAD      3
`define BST_ADDR_W      7
`define BST_DATA_W      8
`define BST_LEN_BYPASS  6'h01
`define BST_LEN_BSR     6'h18
`define BST_LEN_ID      6'h20
`define BST_LEN_RA      6'h0f

// Identification fields: arbitrary values
`define BST_ID_VERSION  4'h5
`define BST_ID_PART     16'h1a2b
`define BST_ID_MAKER    11'h0c3
`define BST_IDCODE      {`BST_ID_VERSION, `BST_ID_PART, `BST_ID_MAKER, 1'b1}

`endif

// ===== rtl/bst_pkg.sv
// Types of the boundary-scan test access port.
// Assumes nothing beyond a SystemVerilog compiler.
package bst_pkg;

    typedef enum logic [3:0] {
        TLR, RTI, SEL_DR, CAP_DR, SHIFT_DR, EXIT1_DR, PAUSE_DR, EXIT2_DR, UPD_DR,
        SEL_IR, CAP_IR, SHIFT_IR, EXIT1_IR, PAUSE_IR, EXIT2_IR, UPD_IR
    } bst_state_type;

endpackage

// ===== rtl/bst_sync.sv
// Two-flop synchroniser for inputs from outside the clock domain.
// Assumes a free-running clk; ce freezes the stages.
`timescale 1ns/1ns
module bst_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_ff <= '0;
            q       <= '0;
        end else if (ce) begin
            meta_ff <= d;
            q       <= meta_ff;
        end
    end
endmodule // bst_sync

// ===== rtl/bst_tap.sv
// Boundary-scan test access port with boundary register and scan register access.
// Assumes tck, tms, tdi and pad inputs are asynchronous; core-side inputs share clk.
`timescale 1ns/1ns
`include "bst_defs.svh"

// Notes on behaviour
// - Codes 0,1,2,3,4,5,7 decode to standard instructions
// - Codes 8,9,10: switch, register read, write
// - State advances on tck rise using tms
// - Five tms-high rises reach Test-Logic-Reset
// - Test-Logic-Reset loads identification instruction
// - Stopped tck keeps state and registers
// - tdi shifted on rise into selected chain
// - tdo changes on tck fall only
// - tdo released unless shifting
// - Bypass is one bit, core untouched
// - Twenty-four cells, controls above even bidir cells
// - Cell types per pin class
// - Identification word with lsb one
// - User code from first configuration bytes
// - Switch bit one disables host, enables access
// - Read capture loads address, update takes new
module bst_tap (
    input  wire logic                     clk,
    input  wire logic                     rst_b,
    input  wire logic                     ce,
    input  wire logic                     tck,
    input  wire logic                     tms,
    input  wire logic                     tdi,
    output logic                          tdo,
    output logic                          tdo_oe,
    input  wire logic [`BST_PADS-1:0]     core_do,
    input  wire logic [`BST_PADS-1:0]     core_oe,
    input  wire logic                     core_aux_do,
    input  wire logic [`BST_PADS-1:0]     pad_di,
    output logic      [`BST_PADS-1:0]     pad_do,
    output logic      [`BST_PADS-1:0]     pad_oe,
    output logic                          pad_aux_do,
    input  wire logic [`BST_DR_W-1:0]     user_code,
    output logic                          host_if_disable,
    output logic      [`BST_ADDR_W-1:0]   reg_addr,
    input  wire logic [`BST_DATA_W-1:0]   reg_rd_data,
    output logic                          reg_wr_stb,
    output logic      [`BST_ADDR_W-1:0]   reg_wr_addr,
    output logic      [`BST_DATA_W-1:0]   reg_wr_data
);
    import bst_pkg::*;

    logic                    tck_s;
    logic                    tms_s;
    logic                    tdi_s;
    logic [`BST_PADS-1:0]    pad_di_s;
    logic                    tck_d_ff;
    logic                    tck_rise;
    logic                    tck_fall;
    logic [2:0]              settle_ff;
    bst_state_type           state_ff;
    bst_state_type           nxt_state;
    logic [`BST_IR_W-1:0]    ir_ff;
    logic [`BST_IR_W-1:0]    ir_sh_ff;
    logic [`BST_DR_W-1:0]    dr_ff;
    logic [`BST_DR_W-1:0]    nxt_dr_shift;
    logic [`BST_DR_W-1:0]    dr_capture;
    logic [5:0]              dr_len;
    logic [`BST_BSR_LEN-1:0] bsr_upd_ff;
    logic [`BST_BSR_LEN-1:0] bsr_cap;
    logic                    if_sw_ff;
    logic                    test_mode;
    logic                    step;
    logic [2:0]              tms_hi_cnt_ff;

    // Pins pass two flops; tms and tdi share the tck delay so they line up at its edges
    bst_sync #(
        .WIDTH (`BST_PADS + 3)
    ) u_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .ce    (ce),
        .d     ({pad_di, tck, tms, tdi}),
        .q     ({pad_di_s, tck_s, tms_s, tdi_s})
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tck_d_ff  <= 1'b1;
            settle_ff <= 3'h0;
        end else if (ce) begin
            tck_d_ff  <= tck_s;
            settle_ff <= {settle_ff[1:0], 1'b1};
        end
    end

    // Edges found here; a stopped tck yields none, so every tap register holds.
    // Sync stages reset low while the pin idles high: no edge until the history is real
    assign tck_rise = tck_s & ~tck_d_ff & settle_ff[2];
    assign tck_fall = ~tck_s & tck_d_ff & settle_ff[2];
    assign step     = tck_rise & ce;

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TLR:      nxt_state = tms_s ? TLR      : RTI;
            RTI:      nxt_state = tms_s ? SEL_DR   : RTI;
            SEL_DR:   nxt_state = tms_s ? SEL_IR   : CAP_DR;
            CAP_DR:   nxt_state = tms_s ? EXIT1_DR : SHIFT_DR;
            SHIFT_DR: nxt_state = tms_s ? EXIT1_DR : SHIFT_DR;
            EXIT1_DR: nxt_state = tms_s ? UPD_DR   : PAUSE_DR;
            PAUSE_DR: nxt_state = tms_s ? EXIT2_DR : PAUSE_DR;
            EXIT2_DR: nxt_state = tms_s ? UPD_DR   : SHIFT_DR;
            UPD_DR:   nxt_state = tms_s ? SEL_DR   : RTI;
            SEL_IR:   nxt_state = tms_s ? TLR      : CAP_IR;
            CAP_IR:   nxt_state = tms_s ? EXIT1_IR : SHIFT_IR;
            SHIFT_IR: nxt_state = tms_s ? EXIT1_IR : SHIFT_IR;
            EXIT1_IR: nxt_state = tms_s ? UPD_IR   : PAUSE_IR;
            PAUSE_IR: nxt_state = tms_s ? EXIT2_IR : PAUSE_IR;
            EXIT2_IR: nxt_state = tms_s ? UPD_IR   : SHIFT_IR;
            UPD_IR:   nxt_state = tms_s ? SEL_DR   : RTI;
            default:  nxt_state = TLR;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_ff <= TLR;
        end else if (step) begin
            state_ff <= nxt_state;
        end
    end

    // Instruction chain and its update stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ir_ff    <= `BST_IR_IDCODE;
            ir_sh_ff <= `BST_IR_CAPTURE;
        end else if (step) begin
            if (nxt_state == TLR) begin
                ir_ff <= `BST_IR_IDCODE;
            end else if (state_ff == UPD_IR) begin
                ir_ff <= ir_sh_ff;
            end
            if (state_ff == CAP_IR) begin
                ir_sh_ff <= `BST_IR_CAPTURE;
            end else if (state_ff == SHIFT_IR) begin
                ir_sh_ff <= {tdi_s, ir_sh_ff[`BST_IR_W-1:1]};
            end
        end
    end

    // Chain length per instruction; unknown codes fall back to the one-bit bypass
    always_comb begin
        case (ir_ff)
            `BST_IR_SAMPLE, `BST_IR_EXTEST:     dr_len = `BST_LEN_BSR;
            `BST_IR_IDCODE, `BST_IR_USERCODE:   dr_len = `BST_LEN_ID;
            `BST_IR_REGRD, `BST_IR_REGWR:       dr_len = `BST_LEN_RA;
            default:                            dr_len = `BST_LEN_BYPASS;
        endcase
    end

    always_comb begin
        dr_capture = '0;
        case (ir_ff)
            `BST_IR_SAMPLE, `BST_IR_EXTEST: dr_capture[`BST_BSR_LEN-1:0] = bsr_cap;
            `BST_IR_IDCODE:   dr_capture = `BST_IDCODE;
            `BST_IR_USERCODE: dr_capture = user_code;
            `BST_IR_IFSWITCH: dr_capture[0] = if_sw_ff;
            `BST_IR_REGRD: begin
                dr_capture[`BST_ADDR_W-1:0] = reg_addr;
                dr_capture[`BST_LEN_RA-1:`BST_ADDR_W] = if_sw_ff ? reg_rd_data : '0;
            end
            `BST_IR_REGWR:    dr_capture[`BST_ADDR_W-1:0] = reg_addr;
            default:          dr_capture = '0;
        endcase
    end

    // Shift right; tdi enters at the top cell of the selected length
    genvar gb;
    generate
        for (gb = 0; gb < `BST_DR_W; gb++) begin : g_dr
            if (gb == `BST_DR_W - 1) begin : g_top
                assign nxt_dr_shift[gb] = (dr_len == 6'(gb + 1)) ? tdi_s : 1'b0;
            end else begin : g_mid
                assign nxt_dr_shift[gb] = (dr_len == 6'(gb + 1)) ? tdi_s : dr_ff[gb + 1];
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            dr_ff <= '0;
        end else if (step) begin
            if (state_ff == CAP_DR) begin
                dr_ff <= dr_capture;
            end else if (state_ff == SHIFT_DR) begin
                dr_ff <= nxt_dr_shift;
            end
        end
    end

    // Update-DR effects
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bsr_upd_ff <= '0;
            if_sw_ff   <= 1'b0;
            reg_addr   <= '0;
        end else if (step) begin
            if (nxt_state == TLR) begin
                if_sw_ff <= 1'b0;
            end else if (state_ff == UPD_DR) begin
                case (ir_ff)
                    `BST_IR_SAMPLE, `BST_IR_EXTEST: bsr_upd_ff <= dr_ff[`BST_BSR_LEN-1:0];
                    `BST_IR_IFSWITCH: if_sw_ff <= dr_ff[0];
                    `BST_IR_REGRD:    reg_addr <= dr_ff[`BST_ADDR_W-1:0];
                    default:          if_sw_ff <= if_sw_ff;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_wr_stb  <= 1'b0;
            reg_wr_addr <= '0;
            reg_wr_data <= '0;
        end else if (ce) begin
            reg_wr_stb <= 1'b0;
            if (tck_rise && state_ff == UPD_DR && ir_ff == `BST_IR_REGWR && if_sw_ff) begin
                reg_wr_stb  <= 1'b1;
                reg_wr_addr <= dr_ff[`BST_ADDR_W-1:0];
                reg_wr_data <= dr_ff[`BST_LEN_RA-1:`BST_ADDR_W];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            host_if_disable <= 1'b0;
        end else if (ce) begin
            host_if_disable <= if_sw_ff;
        end
    end

    // Falling edge drives tdo so a downstream device samples it stable
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tdo    <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall && ce) begin
            tdo    <= (state_ff == SHIFT_IR) ? ir_sh_ff[0] : dr_ff[0];
            tdo_oe <= (state_ff == SHIFT_IR) || (state_ff == SHIFT_DR);
        end
    end

    assign test_mode = (ir_ff == `BST_IR_EXTEST) || (ir_ff == `BST_IR_CLAMP) || (ir_ff == `BST_IR_HIGHZ);

    // Pad k: data cell 2k, control 2k+1; the open-drain pad has an input-type
    // cell and gives its odd slot (cell 7) to the second output
    genvar gp;
    generate
        for (gp = 0; gp < `BST_PADS; gp++) begin : g_pad
            assign bsr_cap[2 * gp] = pad_di_s[gp];
            if (gp == `BST_OD_PAD) begin : g_od
                assign bsr_cap[2 * gp + 1] = core_aux_do;
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        pad_do[gp] <= 1'b0;
                        pad_oe[gp] <= 1'b0;
                    end else if (ce) begin
                        pad_do[gp] <= test_mode ? 1'b0 : core_do[gp];
                        pad_oe[gp] <= (ir_ff == `BST_IR_HIGHZ) ? 1'b0 :
                                      test_mode ? ~bsr_upd_ff[2 * gp] : core_oe[gp];
                    end
                end
            end else begin : g_bidir
                assign bsr_cap[2 * gp + 1] = core_oe[gp];
                always_ff @(posedge clk or negedge rst_b) begin
                    if (!rst_b) begin
                        pad_do[gp] <= 1'b0;
                        pad_oe[gp] <= 1'b0;
                    end else if (ce) begin
                        pad_do[gp] <= test_mode ? bsr_upd_ff[2 * gp] : core_do[gp];
                        pad_oe[gp] <= (ir_ff == `BST_IR_HIGHZ) ? 1'b0 :
                                      test_mode ? bsr_upd_ff[2 * gp + 1] : core_oe[gp];
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pad_aux_do <= 1'b0;
        end else if (ce) begin
            pad_aux_do <= test_mode ? bsr_upd_ff[2 * `BST_OD_PAD + 1] : core_aux_do;
        end
    end

    // Checking helpers: run of tck rises with tms high
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            tms_hi_cnt_ff <= '0;
        end else if (step) begin
            tms_hi_cnt_ff <= !tms_s ? 3'h0 : (tms_hi_cnt_ff == 3'h7) ? 3'h7 : tms_hi_cnt_ff + 3'h1;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    property p_five_high;
        step && tms_s && tms_hi_cnt_ff >= 3'h4 |=> state_ff == TLR;
    endproperty
    a_five_high: assert property (p_five_high) else $error("five tms-high rises missed reset");

    property p_tlr_ir;
        state_ff == TLR |-> ir_ff == `BST_IR_IDCODE;
    endproperty
    a_tlr_ir: assert property (p_tlr_ir) else $error("instruction not identification in reset state");

    property p_frozen;
        !step |=> $stable(state_ff) && $stable(ir_ff) && $stable(dr_ff) && $stable(ir_sh_ff);
    endproperty
    a_frozen: assert property (p_frozen) else $error("tap state moved without tck rise");

    property p_rti_step;
        step && state_ff == RTI && tms_s |=> state_ff == SEL_DR;
    endproperty
    a_rti_step: assert property (p_rti_step) else $error("wrong next state from idle");

    property p_tdo_fall;
        $changed(tdo) || $changed(tdo_oe) |-> $past(tck_fall && ce);
    endproperty
    a_tdo_fall: assert property (p_tdo_fall) else $error("tdo changed off a falling edge");

    property p_tdo_release;
        tck_fall && ce && state_ff != SHIFT_DR && state_ff != SHIFT_IR |=> !tdo_oe;
    endproperty
    a_tdo_release: assert property (p_tdo_release) else $error("tdo driven outside shift");

    property p_bypass_shift;
        step && state_ff == SHIFT_DR && dr_len == `BST_LEN_BYPASS |=> dr_ff[0] == $past(tdi_s);
    endproperty
    a_bypass_shift: assert property (p_bypass_shift) else $error("bypass cell missed tdi");

    property p_id_capture;
        step && state_ff == CAP_DR && ir_ff == `BST_IR_IDCODE |=> dr_ff == `BST_IDCODE && dr_ff[0];
    endproperty
    a_id_capture: assert property (p_id_capture) else $error("identification capture wrong");

    property p_wr_gate;
        reg_wr_stb |-> if_sw_ff && $past(ir_ff == `BST_IR_REGWR && state_ff == UPD_DR);
    endproperty
    a_wr_gate: assert property (p_wr_gate) else $error("register write without switch");

    property p_rd_addr;
        step && state_ff == UPD_DR && ir_ff == `BST_IR_REGRD |=> reg_addr == $past(dr_ff[`BST_ADDR_W-1:0]);
    endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("read address not taken at update");

    property p_highz;
        ce && ir_ff == `BST_IR_HIGHZ |=> pad_oe == '0;
    endproperty
    a_highz: assert property (p_highz) else $error("pads driven under high impedance");

    c_reset_seq: cover property (step && tms_s && tms_hi_cnt_ff == 3'h4);
    c_reg_write: cover property (reg_wr_stb);
    c_read_shift: cover property (step && state_ff == SHIFT_DR && ir_ff == `BST_IR_REGRD);
    c_extest: cover property (ir_ff == `BST_IR_EXTEST && state_ff == UPD_DR);
endmodule // bst_tap

// ===== verif/bst_ctrl_model.sv
// Behavioural boundary-scan test controller that drives the link pins.
// Assumes the bench clk; tck parks high and tms, tdi are driven high after each scan.
`timescale 1ns/1ns
module bst_ctrl_model (
    input  wire logic clk,
    output logic      tck,
    output logic      tms,
    output logic      tdi,
    input  wire logic tdo,
    input  wire logic tdo_oe
);
    logic oe_all;
    logic idle_oe;
    logic tdo_stable;

    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b1;
        oe_all = 1'b1;
        idle_oe = 1'b0;
        tdo_stable = 1'b1;
    end

    // One tck period of 800 ns; tdo is read twice in the high half to catch a change there
    task automatic step(input logic m, input logic d, output logic q, output logic o);
        logic early;
        @(posedge clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (4) @(posedge clk);
        tck <= 1'b1;
        @(negedge clk);
        // A released tdo has no pull: read it inverted so a stale level cannot pass
        early = tdo_oe ? tdo : ~tdo;
        repeat (3) @(negedge clk);
        q = tdo_oe ? tdo : ~tdo;
        o = tdo_oe;
        if (early !== q) begin
            tdo_stable = 1'b0;
        end
    endtask

    // From Run-Test/Idle through one scan of n bits back to Run-Test/Idle
    task automatic shift(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
        logic q;
        logic o;
        dout = '0;
        oe_all = 1'b1;
        step(1'b1, 1'b1, q, o);
        if (ir) begin
            step(1'b1, 1'b1, q, o);
        end
        step(1'b0, 1'b1, q, o);
        step(1'b0, 1'b1, q, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], q, o);
            dout[i] = q;
            oe_all = oe_all & o;
        end
        step(1'b1, 1'b1, q, o);
        idle_oe = o;
        step(1'b0, 1'b1, q, o);
        @(posedge clk);
        tms <= 1'b1;
        tdi <= 1'b1;
        // Outputs launched at this edge are read a clock and a half later, never in its time step
        repeat (2) @(negedge clk);
    endtask

    // Five rises with tms high, then park in Run-Test/Idle
    task automatic tlr_reset();
        logic q;
        logic o;
        repeat (5) step(1'b1, 1'b1, q, o);
        step(1'b0, 1'b1, q, o);
    endtask
endmodule // bst_ctrl_model

// ===== verif/test_bst_tap.sv
// Self-checking bench for the boundary-scan access port.
// Assumes bst_ctrl_model drives the link; the bench plays core, pads and register file.
`timescale 1ns/1ns
`include "bst_defs.svh"
module test_bst_tap;
    logic        clk;
    logic        rst_b;
    logic        ce;
    logic        tck;
    logic        tms;
    logic        tdi;
    logic        tdo;
    logic        tdo_oe;
    logic [11:0] core_do;
    logic [11:0] core_oe;
    logic        core_aux_do;
    logic [11:0] pad_di;
    logic [11:0] pad_do;
    logic [11:0] pad_oe;
    logic        pad_aux_do;
    logic [31:0] user_code;
    logic        host_if_disable;
    logic [6:0]  reg_addr;
    logic [7:0]  reg_rd_data;
    logic        reg_wr_stb;
    logic [6:0]  reg_wr_addr;
    logic [7:0]  reg_wr_data;
    int          bad_count = 0;
    int          num_checks = 0;
    int          stb_count = 0;

    // Register file answers at once from the read pointer
    assign reg_rd_data = {1'b1, reg_addr} ^ 8'h5c;

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        if (reg_wr_stb === 1'b1) begin
            stb_count <= stb_count + 1;
        end
    end

    bst_tap dut (.clk(clk), .rst_b(rst_b), .ce(ce), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe(tdo_oe), .core_do(core_do), .core_oe(core_oe), .core_aux_do(core_aux_do),
        .pad_di(pad_di), .pad_do(pad_do), .pad_oe(pad_oe), .pad_aux_do(pad_aux_do),
        .user_code(user_code), .host_if_disable(host_if_disable), .reg_addr(reg_addr),
        .reg_rd_data(reg_rd_data), .reg_wr_stb(reg_wr_stb), .reg_wr_addr(reg_wr_addr),
        .reg_wr_data(reg_wr_data));

    bst_ctrl_model ctl (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, bad_count);
        if (bad_count == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic t_id();
        logic [31:0] v;
        check("tdo_oe after reset", tdo_oe, 1'b0);
        // Reset leaves the port in Test-Logic-Reset; every scan starts from idle
        ctl.tlr_reset();
        ctl.shift(1'b1, 4, `BST_IR_USERCODE, v);
        check("instruction capture", v[3:0], 4'h1);
        ctl.tlr_reset();
        ctl.shift(1'b0, 32, 32'h0, v);
        check("default identification", v, `BST_IDCODE);
        check("tdo_oe while shifting", ctl.oe_all, 1'b1);
        check("tdo_oe after shifting", ctl.idle_oe, 1'b0);
        $display("done: identification");
    endtask

    task automatic t_user();
        logic [31:0] v;
        ctl.shift(1'b1, 4, `BST_IR_USERCODE, v);
        repeat (400) @(posedge clk);
        ce      <= 1'b0;
        core_do <= 12'h5a3;
        repeat (4) @(negedge clk);
        check("pads frozen while ce low", pad_do, 12'ha5c);
        @(posedge clk);
        ce <= 1'b1;
        repeat (2) @(negedge clk);
        check("pads follow core after ce", pad_do, 12'h5a3);
        ctl.shift(1'b0, 32, 32'h0, v);
        check("user code after stopped tck", v, user_code);
        $display("done: user code");
    endtask

    task automatic t_bypass();
        logic [31:0] v;
        logic [3:0]  codes [6];
        codes = '{`BST_IR_BYPASS, `BST_IR_CLAMP, `BST_IR_HIGHZ, 4'h6, 4'hb, 4'hf};
        for (int i = 0; i < 6; i++) begin
            ctl.shift(1'b1, 4, {28'h0, codes[i]}, v);
            ctl.shift(1'b0, 9, 32'h1a5, v);
            check("one-bit path", v[8:0], 9'h14a);
        end
        $display("done: bypass");
    endtask

    task automatic t_bound();
        logic [31:0] v;
        logic [23:0] e;
        logic [23:0] p;
        logic [11:0] edo;
        logic [11:0] eoe;
        p = 24'h5a9c36;
        ctl.shift(1'b1, 4, `BST_IR_SAMPLE, v);
        ctl.shift(1'b0, 24, {8'h0, p}, v);
        for (int k = 0; k < 12; k++) begin
            e[2*k] = pad_di[k];
            e[2*k+1] = core_oe[k];
            edo[k] = p[2*k];
            eoe[k] = p[2*k+1];
        end
        e[7] = core_aux_do;
        edo[3] = 1'b0;
        eoe[3] = ~p[6];
        check("boundary capture", v[23:0], e);
        check("pads during sample", pad_do, core_do);
        ctl.shift(1'b1, 4, `BST_IR_EXTEST, v);
        check("extest pad values", pad_do, edo);
        check("extest pad enables", pad_oe, eoe);
        check("extest second output", pad_aux_do, p[7]);
        ctl.shift(1'b1, 4, `BST_IR_CLAMP, v);
        check("clamp pad values", pad_do, edo);
        ctl.shift(1'b1, 4, `BST_IR_HIGHZ, v);
        check("high-z enables", pad_oe, 12'h000);
        ctl.shift(1'b1, 4, `BST_IR_BYPASS, v);
        check("functional enables", pad_oe, core_oe);
        check("functional second output", pad_aux_do, core_aux_do);
        $display("done: boundary");
    endtask

    task automatic t_regs();
        logic [31:0] v;
        ctl.shift(1'b1, 4, `BST_IR_REGWR, v);
        ctl.shift(1'b0, 15, {17'h0, 8'h11, 7'h22}, v);
        check("write refused while switch clear", stb_count, 0);
        ctl.shift(1'b1, 4, `BST_IR_IFSWITCH, v);
        ctl.shift(1'b0, 1, 32'h1, v);
        check("host interface disabled", host_if_disable, 1'b1);
        ctl.shift(1'b1, 4, `BST_IR_REGWR, v);
        ctl.shift(1'b0, 15, {17'h0, 8'hc3, 7'h5a}, v);
        check("single write strobe cycle", stb_count, 1);
        check("write address", reg_wr_addr, 7'h5a);
        check("write data", reg_wr_data, 8'hc3);
        ctl.shift(1'b1, 4, `BST_IR_REGRD, v);
        ctl.shift(1'b0, 15, {17'h0, 8'h00, 7'h31}, v);
        check("read pointer update", reg_addr, 7'h31);
        ctl.shift(1'b0, 15, {17'h0, 8'h00, 7'h0c}, v);
        check("read capture address", v[6:0], 7'h31);
        check("read capture data", v[14:7], 8'hb1 ^ 8'h5c);
        ctl.tlr_reset();
        check("switch cleared by test reset", host_if_disable, 1'b0);
        $display("done: register access");
    endtask

    initial begin
        rst_b = 1'b0;
        ce = 1'b1;
        core_do = 12'ha5c;
        core_oe = 12'h3f0;
        core_aux_do = 1'b1;
        pad_di = 12'h6b3;
        user_code = 32'h9e3c1d47;
        repeat (5) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        t_id();
        t_user();
        t_bypass();
        t_bound();
        t_regs();
        check("tdo still in tck high", ctl.tdo_stable, 1'b1);
        complete_run();
    end

    // A hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge clk);
        bad_count++;
        $display("[ERR] watchdog expected finish seen hang");
        complete_run();
    end
endmodule // test_bst_tap
